//--- bench/pcl_loader_monitor.sv
// Purpose: port checks of the loader
// Assumes: one pclk domain
// Notes: port index is mem_addr[3:1]
`timescale 1ns/1ps
`default_nettype none
module pcl_loader_monitor (
  // clock, reset
  input wire logic pclk,
  input wire logic presetn,
  // apb and memory
  input wire logic penable,
  input wire logic pready,
  input wire logic mem_req,
  input wire logic [7:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // configuration
  input wire pcl_pkg::pcl_port_cfg_t [pcl_pkg::NUM_PORTS-1:0] port_cfg,
  input wire logic [pcl_pkg::NUM_PORTS-1:0][11:0] replay_tmo_eff,
  input wire logic load_done
);
  logic [3:0] g;
  logic [2:0] p;
  assign g = (mem_req && mem_ack) ? mem_addr[7:4] : 4'h0;
  assign p = mem_addr[3:1];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SLOT_LO: assert property (g == 4'h9 |=>
    port_cfg[$past(p)].slot_cap[15:0] == $past(mem_rdata)) else $error("slot lo");
  AST_SLOT_HI: assert property (g == 4'hA |=>
    port_cfg[$past(p)].slot_cap[31:16] == $past(mem_rdata)) else $error("slot hi");
  AST_XCVR_LO: assert property (g == 4'hB |=>
    port_cfg[$past(p)].xcvr_ctl[15:0] == $past(mem_rdata)) else $error("xcvr lo");
  AST_XCVR_HI: assert property (g == 4'hC |=>
    port_cfg[$past(p)].xcvr_ctl[31:16] == $past(mem_rdata)) else $error("xcvr hi");
  AST_TMO_LOW: assert property (g == 4'hD && p < 3 |=>
    port_cfg[$past(p)].replay_tmo == $past(mem_rdata[11:0])) else $error("tmo");
  AST_TMO_EN: assert property (g == 4'hD |=> replay_tmo_eff[$past(p)] ==
    ($past(mem_rdata[12]) ? $past(mem_rdata[11:0]) : pcl_pkg::TMO_DEFAULT)) else $error("en");
  AST_TS_CTL: assert property (g == 4'hD |=>
    port_cfg[$past(p)].ts_ctl == $past(mem_rdata[14:13])) else $error("ts");
  AST_TMO_HIGH: assert property (g == 4'hD && p > 2 |=> port_cfg[$past(p)][14:0] ==
    {$past(mem_rdata[11:0]), $past(mem_rdata[12]), $past(mem_rdata[14:13])}) else $error("hi");
  AST_NO_EARLY: assert property (penable && pready |-> load_done) else $error("early");
endmodule : pcl_loader_monitor
bind pcl_loader pcl_loader_monitor u_mon (.pclk(pclk), .presetn(presetn), .penable(penable),
  .pready(pready), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .port_cfg(port_cfg), .replay_tmo_eff(replay_tmo_eff),
  .load_done(load_done));
`default_nettype wire

//--- bench/pcl_mem_model.sv
// Purpose: setup word memory
// Assumes: word is {addr ^ key, addr ^ 3Ch}
// Notes: lat sets wait cycles, data inverted when idle
`timescale 1ns/1ps
`default_nettype none
module pcl_mem_model (
  // clock, reset
  input wire logic pclk,
  input wire logic presetn,
  // request and knobs
  input wire logic mem_req,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] key,
  input wire logic [3:0] lat,
  // answer
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [3:0] cnt_reg, cnt_next;
  logic ack_next;
  logic [15:0] word, last_reg, last_next;
  assign word = {mem_addr ^ key, mem_addr ^ 8'h3C};
  assign mem_rdata = mem_ack ? word : ~last_reg;
  always_comb
  begin
    ack_next = mem_req && (cnt_reg == lat);
    cnt_next = (ack_next || !mem_req) ? 4'h0 : cnt_reg + 4'h1;
    last_next = mem_ack ? word : last_reg;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      cnt_reg <= 4'h0;
      last_reg <= 16'h0000;
    end
    else
    begin
      mem_ack <= ack_next;
      cnt_reg <= cnt_next;
      last_reg <= last_next;
    end
  end
endmodule : pcl_mem_model
`default_nettype wire

//--- bench/testbench.sv
// Purpose: loader bench
// Assumes: memory model on pclk
// Notes: expected words from addr and key
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic pready, pslverr, mem_req, mem_ack, load_done;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] mem_addr, key = 0;
  logic [15:0] mem_rdata;
  logic [3:0] lat = 3;
  pcl_pkg::pcl_port_cfg_t [5:0] port_cfg;
  logic [5:0][11:0] eff;
  int failures = 0, n_checks = 0, cyc = 0;
  always #4 pclk = ~pclk;
  pcl_loader dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .port_cfg(port_cfg), .replay_tmo_eff(eff), .load_done(load_done));
  pcl_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .key(key), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  function automatic logic [15:0] w(input logic [7:0] a);
    return {a ^ key, a ^ 8'h3C};
  endfunction : w
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic table_run();
    logic [11:0] ra [24];
    logic [31:0] re [24];
    logic [11:0] ee [6];
    logic [7:0] ofs [4] = '{8'h70, 8'h80, 8'h8C, 8'hD4};
    logic [7:0] o;
    logic [15:0] r;
    for (int i = 0; i < 24; i++)
    begin
      o = 8'(i / 4 * 2);
      r = w(8'hD0 + o);
      ra[i] = {4'(i / 4), ofs[i % 4]};
      re[i] = (i % 4 == 0) ? {19'h0, r[12:0]} : (i % 4 == 1) ? {w(8'hC0 + o), w(8'hB0 + o)} :
        (i % 4 == 2) ? {6'h0, r[14:13], 24'h0} : (i < 4) ? 0 : {w(8'hA0 + o), w(8'h90 + o)};
      if (i % 4 == 0)
        ee[i / 4] = r[12] ? r[11:0] : pcl_pkg::TMO_DEFAULT;
    end
    for (int i = 0; i < 24; i++)
    begin
      apb(0, ra[i], 0);
      chk(rd, re[i]);
      if (i % 4 == 0)
        chk(eff[i / 4], ee[i / 4]);
    end
  endtask : table_run
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (5) @(posedge pclk);
    chk(port_cfg[2].slot_cap, 0);
    chk(eff[2], 12'h0FF);
    presetn <= 1;
    apb(0, 12'h804, 0);
    chk(rd, 1);
    chk(load_done, 1);
    chk(mem_req, 0);
    for (int i = 0; i < 4; i++)
    begin
      apb(i == 3, 12'h900 - 12'(i * 12'h190), 32'hFFFF_FFFF);
      chk(err, 1);
    end
    table_run();
    key <= 8'h70;
    lat <= 0;
    apb(1, 12'h800, 1);
    table_run();
    apb(1, 12'h800, 1);
    repeat (8) @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    chk(port_cfg[1].xcvr_ctl, 0);
    presetn <= 1;
    apb(0, 12'h804, 0);
    chk(rd, 1);
    final_report();
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      failures++;
      final_report();
    end
  end
endmodule : testbench
`default_nettype wire

//--- logic/pcl_loader.sv
// Purpose: fetch setup words from configuration memory into per-port fields
// Assumes: configuration memory runs on pclk and answers with mem_ack
// Notes: APB accesses stall until the load has completed
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RL1 - words at 92h..9Ah fill the low half of the slot capability of ports 1 to 5.
// RL2 - words at A2h..AAh fill the high half of the slot capability of ports 1 to 5.
// RL3 - words at B0h..BAh fill the low half of transceiver control word 3 of ports 0 to 5.
// RL4 - words at C0h..CAh fill the high half of transceiver control word 3 of ports 0 to 5.
// RL5 - bits 11:0 of words D0h..D4h become the replay time-out value of ports 0 to 2.
// RL6 - bit 12 of a replay word is the enable that selects the loaded time-out over default.
// RL7 - bits 14:13 of a replay word go to the received training-set control at 8Ch bits 25:24.
// RL8 - words D6h..DAh do the same replay mapping for ports 3 to 5.
// RL9 - loaded fields replace defaults before any config access; others keep their defaults.
module pcl_loader (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration memory
  output logic mem_req,
  output logic [7:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // port configuration
  output pcl_pkg::pcl_port_cfg_t [pcl_pkg::NUM_PORTS-1:0] port_cfg,
  output logic [pcl_pkg::NUM_PORTS-1:0][11:0] replay_tmo_eff,
  output logic load_done
);

  typedef enum logic [1:0] {
    PCL_FETCH,
    PCL_DONE
  } pcl_state_t;

  function automatic pcl_pkg::pcl_tgt_t step_tgt(input logic [4:0] s);
    pcl_pkg::pcl_tgt_t t;
    logic [4:0] rel;
    t = '{kind: pcl_pkg::PCL_REPLAY, port: 3'h0, addr: 8'h00};
    if (s < pcl_pkg::STEP_SLOT_HI)
    begin
      rel = s - pcl_pkg::STEP_SLOT_LO;
      t.kind = pcl_pkg::PCL_SLOT_LO;
      t.port = rel[2:0] + 3'h1;
      t.addr = pcl_pkg::ADDR_SLOT_LO + {2'b00, rel, 1'b0};
    end
    else if (s < pcl_pkg::STEP_XCVR_LO)
    begin
      rel = s - pcl_pkg::STEP_SLOT_HI;
      t.kind = pcl_pkg::PCL_SLOT_HI;
      t.port = rel[2:0] + 3'h1;
      t.addr = pcl_pkg::ADDR_SLOT_HI + {2'b00, rel, 1'b0};
    end
    else if (s < pcl_pkg::STEP_XCVR_HI)
    begin
      rel = s - pcl_pkg::STEP_XCVR_LO;
      t.kind = pcl_pkg::PCL_XCVR_LO;
      t.port = rel[2:0];
      t.addr = pcl_pkg::ADDR_XCVR_LO + {2'b00, rel, 1'b0};
    end
    else if (s < pcl_pkg::STEP_REPLAY)
    begin
      rel = s - pcl_pkg::STEP_XCVR_HI;
      t.kind = pcl_pkg::PCL_XCVR_HI;
      t.port = rel[2:0];
      t.addr = pcl_pkg::ADDR_XCVR_HI + {2'b00, rel, 1'b0};
    end
    else
    begin
      rel = s - pcl_pkg::STEP_REPLAY;
      t.kind = pcl_pkg::PCL_REPLAY;
      t.port = rel[2:0];
      t.addr = pcl_pkg::ADDR_REPLAY + {2'b00, rel, 1'b0};
    end
    return t;
  endfunction : step_tgt

  pcl_state_t state_reg, state_next;
  logic [4:0] step_reg, step_next;
  logic [7:0] addr_reg, addr_next;
  pcl_pkg::pcl_port_cfg_t [pcl_pkg::NUM_PORTS-1:0] cfg_reg, cfg_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic rvalid_reg, rvalid_next;
  pcl_pkg::pcl_tgt_t tgt;
  pcl_pkg::pcl_tgt_t tgt_inc;
  logic access;
  logic reload;

  assign tgt = step_tgt(step_reg);
  assign tgt_inc = step_tgt(step_reg + 5'h01);
  assign access = psel & penable & pready;
  assign reload = access & pwrite & (paddr == pcl_pkg::ADDR_CTRL) & pwdata[pcl_pkg::CTRL_RELOAD];

  // loader sequencing and field updates
  always_comb
  begin
    state_next = state_reg;
    step_next = step_reg;
    addr_next = addr_reg;
    cfg_next = cfg_reg;
    case (state_reg)
      PCL_FETCH:
      begin
        if (mem_ack)
        begin
          case (tgt.kind)
            pcl_pkg::PCL_SLOT_LO: cfg_next[tgt.port].slot_cap[15:0] = mem_rdata; // [RL1]
            pcl_pkg::PCL_SLOT_HI: cfg_next[tgt.port].slot_cap[31:16] = mem_rdata; // [RL2]
            pcl_pkg::PCL_XCVR_LO: cfg_next[tgt.port].xcvr_ctl[15:0] = mem_rdata; // [RL3]
            pcl_pkg::PCL_XCVR_HI: cfg_next[tgt.port].xcvr_ctl[31:16] = mem_rdata; // [RL4]
            pcl_pkg::PCL_REPLAY:
            begin
              // replay word covers all six ports [RL8]
              cfg_next[tgt.port].replay_tmo = mem_rdata[pcl_pkg::SW_TMO_MSB:0]; // [RL5]
              cfg_next[tgt.port].replay_en = mem_rdata[pcl_pkg::SW_TMO_EN]; // [RL6]
              cfg_next[tgt.port].ts_ctl = mem_rdata[pcl_pkg::SW_TS_LSB+:2]; // [RL7]
            end
            default: cfg_next = cfg_reg;
          endcase
          if (step_reg == pcl_pkg::LAST_STEP)
          begin
            state_next = PCL_DONE;
          end
          else
          begin
            step_next = step_reg + 5'h01;
            addr_next = tgt_inc.addr;
          end
        end
      end
      PCL_DONE:
      begin
        if (reload)
        begin
          state_next = PCL_FETCH;
          step_next = pcl_pkg::STEP_SLOT_LO;
          addr_next = pcl_pkg::ADDR_SLOT_LO;
        end
      end
      default: state_next = PCL_FETCH;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= PCL_FETCH;
      step_reg <= pcl_pkg::STEP_SLOT_LO;
      addr_reg <= pcl_pkg::ADDR_SLOT_LO;
      cfg_reg <= {pcl_pkg::NUM_PORTS{pcl_pkg::CFG_DEFAULT}}; // [RL9]
    end
    else
    begin
      state_reg <= state_next;
      step_reg <= step_next;
      addr_reg <= addr_next;
      cfg_reg <= cfg_next;
    end
  end

  // apb read path, stalled until loaded
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    rvalid_next = psel & (state_reg == PCL_DONE) & ~rvalid_reg; // [RL9]
    if (paddr == pcl_pkg::ADDR_CTRL)
    begin
      rdata_next = 32'h0000_0000;
    end
    else if (paddr == pcl_pkg::ADDR_STATUS)
    begin
      rdata_next[pcl_pkg::STAT_DONE] = (state_reg == PCL_DONE);
      rdata_next[pcl_pkg::STAT_BUSY] = (state_reg == PCL_FETCH);
      err_next = pwrite;
    end
    else if (!paddr[11] && paddr[10:8] < 3'(pcl_pkg::NUM_PORTS) && !pwrite)
    begin
      case (paddr[7:0])
        pcl_pkg::OFS_REPLAY:
          rdata_next = {19'h0_0000, cfg_reg[paddr[10:8]].replay_en,
                        cfg_reg[paddr[10:8]].replay_tmo};
        pcl_pkg::OFS_XCVR: rdata_next = cfg_reg[paddr[10:8]].xcvr_ctl;
        pcl_pkg::OFS_TS:
          rdata_next = {6'h00, cfg_reg[paddr[10:8]].ts_ctl, 24'h00_0000};
        pcl_pkg::OFS_SLOT: rdata_next = cfg_reg[paddr[10:8]].slot_cap;
        default: err_next = 1'b1;
      endcase
    end
    else
    begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // effective replay time-out per port
  genvar p;
  generate
    for (p = 0; p < pcl_pkg::NUM_PORTS; p++)
    begin : g_port
      assign replay_tmo_eff[p] = cfg_reg[p].replay_en ? cfg_reg[p].replay_tmo
                                                     : pcl_pkg::TMO_DEFAULT; // [RL6]
    end
  endgenerate

  assign pready = rvalid_reg & penable;
  assign pslverr = rvalid_reg & penable & err_reg;
  assign prdata = rdata_reg;
  assign mem_req = (state_reg == PCL_FETCH);
  assign mem_addr = addr_reg;
  assign port_cfg = cfg_reg;
  assign load_done = (state_reg == PCL_DONE);

endmodule : pcl_loader

`default_nettype wire

//--- logic/pcl_pkg.sv
// Purpose: constants and types for the port configuration word loader
// Assumes: six ports, 16-bit setup words, APB register access
// Notes: port register byte address is port * 100h + configuration offset
package pcl_pkg;
  localparam int NUM_PORTS = 6;
  localparam int NUM_STEPS = 28;
  localparam logic [4:0] LAST_STEP = 5'h1B;

  // fetch plan: first step of each group and its first word address
  localparam logic [4:0] STEP_SLOT_LO = 5'h00;
  localparam logic [4:0] STEP_SLOT_HI = 5'h05;
  localparam logic [4:0] STEP_XCVR_LO = 5'h0A;
  localparam logic [4:0] STEP_XCVR_HI = 5'h10;
  localparam logic [4:0] STEP_REPLAY = 5'h16;
  localparam logic [7:0] ADDR_SLOT_LO = 8'h92;
  localparam logic [7:0] ADDR_SLOT_HI = 8'hA2;
  localparam logic [7:0] ADDR_XCVR_LO = 8'hB0;
  localparam logic [7:0] ADDR_XCVR_HI = 8'hC0;
  localparam logic [7:0] ADDR_REPLAY = 8'hD0;

  // per-port configuration offsets
  localparam logic [7:0] OFS_REPLAY = 8'h70;
  localparam logic [7:0] OFS_XCVR = 8'h80;
  localparam logic [7:0] OFS_TS = 8'h8C;
  localparam logic [7:0] OFS_SLOT = 8'hD4;

  // setup word fields and target field positions
  localparam int SW_TMO_MSB = 11;
  localparam int SW_TMO_EN = 12;
  localparam int SW_TS_LSB = 13;
  localparam int CFG_TS_LSB = 24;

  // loader control block
  localparam logic [11:0] ADDR_CTRL = 12'h0800;
  localparam logic [11:0] ADDR_STATUS = 12'h0804;
  localparam int CTRL_RELOAD = 0;
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;

  // reset defaults
  localparam logic [31:0] SLOT_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] XCVR_DEFAULT = 32'h0000_0000;
  localparam logic [11:0] TMO_DEFAULT = 12'h0_0FF;
  localparam logic [1:0] TS_DEFAULT = 2'h0;

  typedef enum logic [2:0] {
    PCL_SLOT_LO,
    PCL_SLOT_HI,
    PCL_XCVR_LO,
    PCL_XCVR_HI,
    PCL_REPLAY
  } pcl_kind_t;

  typedef struct packed {
    pcl_kind_t kind;
    logic [2:0] port;
    logic [7:0] addr;
  } pcl_tgt_t;

  typedef struct packed {
    logic [31:0] slot_cap;
    logic [31:0] xcvr_ctl;
    logic [11:0] replay_tmo;
    logic replay_en;
    logic [1:0] ts_ctl;
  } pcl_port_cfg_t;

  localparam pcl_port_cfg_t CFG_DEFAULT = '{
    slot_cap: SLOT_DEFAULT,
    xcvr_ctl: XCVR_DEFAULT,
    replay_tmo: TMO_DEFAULT,
    replay_en: 1'b0,
    ts_ctl: TS_DEFAULT
  };
endpackage : pcl_pkg
